// [fp_compare_predicate.sv]
// floating point compare unit with condition codes and register slave
module fp_compare_predicate
   import fp_compare_pkg::*;
#(
   parameter bit NAN_QUIET_HIGH = 1'b1
) (
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   // compare issue port
   input  wire logic                  issue_valid,
   input  wire logic [1:0]            operand_format,
   input  wire logic [3:0]            predicate_select,
   input  wire logic [FLAG_IDX_W-1:0] flag_index,
   input  wire logic [DBL_W-1:0]      first_source,
   input  wire logic [DBL_W-1:0]      second_source,
   input  wire logic                  cop_usable,
   input  wire logic                  unimpl_request,
   // compare results
   output logic                       done,
   output logic                       outcome,
   output logic                       exc_taken,
   output logic [1:0]                 exc_cause,
   output logic                       exc_unimplemented,
   output logic [FLAG_COUNT-1:0]      cond_codes,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0]     avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   output logic                       irq
);

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      logic [FLAG_COUNT-1:0] cc;
      logic                  inv_flag;
      logic                  inv_en;
      logic [IRQ_W-1:0]      irq_status;
      logic [IRQ_W-1:0]      irq_mask;
      logic                  irq;
      logic                  done;
      logic                  outcome;
      logic                  exc_taken;
      logic [1:0]            exc_cause;
      logic                  exc_unimpl;
      logic                  waitreq;
      logic [31:0]           rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ==========================================================
   // ordering relations: one double lane, two single lanes
   // ==========================================================
   logic       dbl_less;
   logic       dbl_equal;
   logic       dbl_unord;
   logic       dbl_snan;
   logic       dbl_qnan;
   logic [1:0] sgl_less;
   logic [1:0] sgl_equal;
   logic [1:0] sgl_unord;
   logic [1:0] sgl_snan;
   logic [1:0] sgl_qnan;

   fp_order_lane #(
      .EXP_W          (DBL_EXP_W),
      .MAN_W          (DBL_MAN_W),
      .NAN_QUIET_HIGH (NAN_QUIET_HIGH)
   ) u_dbl_lane (
      .op_a      (first_source),
      .op_b      (second_source),
      .less      (dbl_less),
      .equal     (dbl_equal),
      .unordered (dbl_unord),
      .snan_any  (dbl_snan),
      .qnan_any  (dbl_qnan)
   );

   for (genvar h = 0; h < 2; h++) begin : g_half
      fp_order_lane #(
         .EXP_W          (SGL_EXP_W),
         .MAN_W          (SGL_MAN_W),
         .NAN_QUIET_HIGH (NAN_QUIET_HIGH)
      ) u_sgl_lane (
         .op_a      (first_source[h*SGL_W +: SGL_W]),
         .op_b      (second_source[h*SGL_W +: SGL_W]),
         .less      (sgl_less[h]),
         .equal     (sgl_equal[h]),
         .unordered (sgl_unord[h]),
         .snan_any  (sgl_snan[h]),
         .qnan_any  (sgl_qnan[h])
      );
   end

   // ==========================================================
   // predicate evaluation
   // ==========================================================
   function automatic logic eval_pred(input logic [3:0] sel, input logic lt,
                                      input logic eq, input logic un);
      eval_pred = (sel[PRED_LESS_BIT] && lt) || (sel[PRED_EQUAL_BIT] && eq)
                  || (sel[PRED_UNORD_BIT] && un);
   endfunction : eval_pred

   function automatic logic raise_inv(input logic [3:0] sel, input logic sn,
                                      input logic qn);
      raise_inv = sn || (sel[PRED_SIGNAL_BIT] && qn);
   endfunction : raise_inv

   // ==========================================================
   // per-lane results: one per single half, one for the double lane
   // ==========================================================
   logic [1:0] half_res;
   logic [1:0] half_inv;
   logic       dbl_res;
   logic       dbl_inv;

   for (genvar h = 0; h < 2; h++) begin : g_eval
      assign half_res[h] = eval_pred(predicate_select, sgl_less[h], sgl_equal[h],
                                     sgl_unord[h]);
      assign half_inv[h] = raise_inv(predicate_select, sgl_snan[h], sgl_qnan[h]);
   end

   assign dbl_res = eval_pred(predicate_select, dbl_less, dbl_equal, dbl_unord);
   assign dbl_inv = raise_inv(predicate_select, dbl_snan, dbl_qnan);

   // ==========================================================
   // format selection
   // ==========================================================
   logic                  res_lo;
   logic                  res_hi;
   logic                  invalid;
   logic                  fmt_ok;
   logic [FLAG_IDX_W-1:0] idx_hi;

   always_comb begin
      res_lo  = 1'b0;
      res_hi  = 1'b0;
      invalid = 1'b0;
      fmt_ok  = 1'b1;
      // odd index: both halves land on one bit, the high half last
      idx_hi  = flag_index | {{(FLAG_IDX_W-1){1'b0}}, 1'b1};
      case (operand_format)
         FMT_SINGLE: begin
            res_lo  = half_res[0];
            invalid = half_inv[0];
         end
         FMT_DOUBLE: begin
            res_lo  = dbl_res;
            invalid = dbl_inv;
         end
         FMT_PAIRED_SINGLE: begin
            res_lo  = half_res[0];
            res_hi  = half_res[1];
            invalid = |half_inv;
         end
         default: begin
            fmt_ok = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // bus answer: waitrequest drops for one cycle per request
   // ==========================================================
   logic bus_req;
   logic bus_answer;

   assign bus_req    = avs_read || avs_write;
   assign bus_answer = bus_req && s_q.waitreq;

   // ==========================================================
   // bus decode helpers
   // ==========================================================
   logic        bus_commit;
   logic        wr_csr;
   logic        wr_status;
   logic        wr_mask;
   logic [31:0] rd_value;

   always_comb begin
      // a write lands only at the edge where waitrequest is low; read data is captured one edge earlier
      bus_commit = bus_req && !s_q.waitreq;
      wr_csr     = 1'b0;
      wr_status  = 1'b0;
      wr_mask    = 1'b0;
      rd_value   = RDATA_ZERO;
      if (avs_address == REG_CSR) begin
         wr_csr   = avs_write && bus_commit;
         rd_value[CSR_INV_FLAG] = s_q.inv_flag;
         rd_value[CSR_INV_EN]   = s_q.inv_en;
         rd_value[CSR_CC_LSB +: FLAG_COUNT] = s_q.cc;
      end else if (avs_address == REG_IRQ_STATUS) begin
         wr_status = avs_write && bus_commit;
         rd_value[IRQ_W-1:0] = s_q.irq_status;
      end else if (avs_address == REG_IRQ_MASK) begin
         wr_mask  = avs_write && bus_commit;
         rd_value[IRQ_W-1:0] = s_q.irq_mask;
      end else begin
         // unmapped offsets read as zero, writes to them are dropped
         rd_value = RDATA_ZERO;
      end
   end

   // ==========================================================
   // exception priority: usability, format, unimplemented
   // ==========================================================
   logic       pre_exc;
   logic [1:0] pre_cause;
   logic       pre_unimpl;

   always_comb begin
      pre_exc    = 1'b1;
      pre_cause  = CAUSE_NONE;
      pre_unimpl = 1'b0;
      if (!cop_usable) begin
         pre_cause = CAUSE_COP_UNUSABLE;
      end else if (!fmt_ok) begin
         pre_cause = CAUSE_RESERVED;
      end else if (unimpl_request) begin
         // unimplemented reports through its own pulse, cause stays none
         pre_unimpl = 1'b1;
      end else begin
         pre_exc = 1'b0;
      end
   end

   // ==========================================================
   // next state
   // ==========================================================
   logic             do_compare;
   logic             trap_inv;
   logic [IRQ_W-1:0] events;

   always_comb begin
      s_d        = s_q;
      do_compare = 1'b0;
      trap_inv   = 1'b0;
      events     = '0;
      s_d.done       = 1'b0;
      s_d.exc_taken  = 1'b0;
      s_d.exc_unimpl = 1'b0;

      if (bus_answer) begin
         s_d.waitreq = 1'b0;
         s_d.rdata   = rd_value;
      end else begin
         s_d.waitreq = 1'b1;
      end

      // software writes first, hardware sets below win over clears
      if (wr_csr) begin
         s_d.inv_en = avs_writedata[CSR_INV_EN];
         if (avs_writedata[CSR_INV_FLAG]) begin
            s_d.inv_flag = 1'b0;
         end
      end
      if (wr_status) begin
         s_d.irq_status = s_q.irq_status & ~avs_writedata[IRQ_W-1:0];
      end
      if (wr_mask) begin
         s_d.irq_mask = avs_writedata[IRQ_W-1:0];
      end

      if (issue_valid) begin
         s_d.done       = 1'b1;
         s_d.outcome    = res_lo;
         s_d.exc_taken  = pre_exc;
         s_d.exc_cause  = pre_cause;
         s_d.exc_unimpl = pre_unimpl;
         events[IRQ_DONE] = 1'b1;
         do_compare = !pre_exc;
      end

      if (do_compare) begin
         if (invalid) begin
            s_d.inv_flag = 1'b1;
            events[IRQ_INVALID] = 1'b1;
            // enable as it stood before any csr write in this same cycle
            trap_inv = s_q.inv_en;
         end
         if (trap_inv) begin
            s_d.exc_taken = 1'b1;
            s_d.exc_cause = CAUSE_INVALID;
         end else if (operand_format == FMT_PAIRED_SINGLE) begin
            s_d.cc[flag_index] = res_lo;
            s_d.cc[idx_hi]     = res_hi;
         end else begin
            s_d.cc[flag_index] = res_lo;
         end
      end
      events[IRQ_EXC] = s_d.exc_taken;

      // a hardware event wins over a clear in the same cycle
      s_d.irq_status = s_d.irq_status | events;
      s_d.irq        = |(s_d.irq_status & s_d.irq_mask);
   end

   // ==========================================================
   // registers
   // ==========================================================
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q            <= '0;
         s_q.cc         <= CC_RESET;
         s_q.irq_mask   <= IRQ_MASK_RESET;
         // waitrequest idles high: a request is answered one edge later
         s_q.waitreq    <= 1'b1;
         s_q.rdata      <= RDATA_ZERO;
         s_q.exc_cause  <= CAUSE_NONE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign done              = s_q.done;
   assign outcome           = s_q.outcome;
   assign exc_taken         = s_q.exc_taken;
   assign exc_cause         = s_q.exc_cause;
   assign exc_unimplemented = s_q.exc_unimpl;
   assign cond_codes        = s_q.cc;
   assign avs_readdata      = s_q.rdata;
   assign avs_waitrequest   = s_q.waitreq;
   assign irq               = s_q.irq;

endmodule : fp_compare_predicate

// [fp_compare_pkg.sv]
// shared constants and encodings for the floating point compare unit
package fp_compare_pkg;

   // ==========================================================
   // operand formats and predicate select fields
   // ==========================================================
   localparam logic [1:0] FMT_SINGLE        = 2'h0;
   localparam logic [1:0] FMT_DOUBLE        = 2'h1;
   localparam logic [1:0] FMT_PAIRED_SINGLE = 2'h2;
   localparam int         PRED_UNORD_BIT    = 0;
   localparam int         PRED_EQUAL_BIT    = 1;
   localparam int         PRED_LESS_BIT     = 2;
   localparam int         PRED_SIGNAL_BIT   = 3;
   localparam int         FLAG_COUNT        = 8;
   localparam int         FLAG_IDX_W        = 3;

   // ==========================================================
   // floating point layouts
   // ==========================================================
   localparam int SGL_EXP_W = 8;
   localparam int SGL_MAN_W = 23;
   localparam int DBL_EXP_W = 11;
   localparam int DBL_MAN_W = 52;
   localparam int SGL_W     = 32;
   localparam int DBL_W     = 64;

   // ==========================================================
   // exception causes
   // ==========================================================
   localparam logic [1:0] CAUSE_NONE        = 2'h0;
   localparam logic [1:0] CAUSE_COP_UNUSABLE = 2'h1;
   localparam logic [1:0] CAUSE_RESERVED    = 2'h2;
   localparam logic [1:0] CAUSE_INVALID     = 2'h3;

   // ==========================================================
   // register map (byte addresses) and fields
   // ==========================================================
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  REG_CSR         = 4'h0;
   localparam logic [3:0]  REG_IRQ_STATUS  = 4'h4;
   localparam logic [3:0]  REG_IRQ_MASK    = 4'h8;
   localparam int          CSR_INV_FLAG    = 0;
   localparam int          CSR_INV_EN      = 1;
   localparam int          CSR_CC_LSB      = 8;
   localparam int          IRQ_W           = 3;
   localparam int          IRQ_DONE        = 0;
   localparam int          IRQ_INVALID     = 1;
   localparam int          IRQ_EXC         = 2;
   localparam logic [7:0]  CC_RESET        = 8'h00;
   localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
   localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

endpackage : fp_compare_pkg

// [fp_order_lane.sv]
// ordering relations and nan detection for one ieee operand pair
module fp_order_lane
   import fp_compare_pkg::*;
#(
   parameter int EXP_W          = 8,
   parameter int MAN_W          = 23,
   parameter bit NAN_QUIET_HIGH = 1'b1
) (
   input  wire logic [EXP_W+MAN_W:0] op_a,
   input  wire logic [EXP_W+MAN_W:0] op_b,
   output logic                      less,
   output logic                      equal,
   output logic                      unordered,
   output logic                      snan_any,
   output logic                      qnan_any
);
   localparam int W = EXP_W + MAN_W + 1;

   logic             nan_a;
   logic             nan_b;
   logic             quiet_a;
   logic             quiet_b;
   logic [W-2:0]     mag_a;
   logic [W-2:0]     mag_b;
   logic             zeros;
   logic             mag_lt;
   logic             mag_gt;

   always_comb begin
      mag_a   = op_a[W-2:0];
      mag_b   = op_b[W-2:0];
      nan_a   = (&op_a[W-2:MAN_W]) && (op_a[MAN_W-1:0] != '0);
      nan_b   = (&op_b[W-2:MAN_W]) && (op_b[MAN_W-1:0] != '0);
      quiet_a = op_a[MAN_W-1] == NAN_QUIET_HIGH;
      quiet_b = op_b[MAN_W-1] == NAN_QUIET_HIGH;
      snan_any = (nan_a && !quiet_a) || (nan_b && !quiet_b);
      qnan_any = (nan_a && quiet_a) || (nan_b && quiet_b);
      // sign of zero is ignored
      zeros   = (mag_a == '0) && (mag_b == '0);
      mag_lt  = mag_a < mag_b;
      mag_gt  = mag_a > mag_b;
      if (nan_a || nan_b) begin
         less      = 1'b0;
         equal     = 1'b0;
         unordered = 1'b1;
      end else begin
         unordered = 1'b0;
         equal     = (op_a == op_b) || zeros;
         if (zeros) begin
            less = 1'b0;
         end else if (op_a[W-1] != op_b[W-1]) begin
            less = op_a[W-1];
         end else if (op_a[W-1]) begin
            less = mag_gt;
         end else begin
            less = mag_lt;
         end
      end
   end

endmodule : fp_order_lane

// [fp_compare_predicate_asserts.sv]
// concurrent checks on the compare unit ports
module fp_compare_predicate_asserts
   import fp_compare_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  arst_n,
   input wire logic                  issue_valid,
   input wire logic [1:0]            operand_format,
   input wire logic [3:0]            predicate_select,
   input wire logic [DBL_W-1:0]      first_source,
   input wire logic [DBL_W-1:0]      second_source,
   input wire logic                  cop_usable,
   input wire logic                  unimpl_request,
   input wire logic                  done,
   input wire logic                  outcome,
   input wire logic                  exc_taken,
   input wire logic [1:0]            exc_cause,
   input wire logic [FLAG_COUNT-1:0] cond_codes,
   input wire logic                  avs_read,
   input wire logic                  avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   sequence s_go;
      issue_valid && cop_usable && !unimpl_request && operand_format == FMT_SINGLE;
   endsequence
   sequence s_res(bit v);
      done && (exc_taken || outcome == v);
   endsequence
   property p_done;
      issue_valid |=> done;
   endproperty
   property p_idle;
      !issue_valid |=> !done && $stable(cond_codes);
   endproperty
   property p_cop;
      issue_valid && !cop_usable |=> exc_taken && exc_cause == CAUSE_COP_UNUSABLE
         && $stable(cond_codes);
   endproperty
   property p_rsv;
      issue_valid && cop_usable && operand_format == 2'h3 |=> exc_cause == CAUSE_RESERVED;
   endproperty
   property p_false;
      s_go ##0 predicate_select[2:0] == 3'h0 |=> s_res(1'b0);
   endproperty
   property p_zero;
      s_go ##0 predicate_select == 4'h2 && first_source[31:0] == 32'h00000000
         && second_source[31:0] == 32'h80000000 |=> s_res(1'b1);
   endproperty
   property p_qnan;
      s_go ##0 first_source[31:0] == 32'h7FC00000 && predicate_select == 4'h1 |=> s_res(1'b1);
   endproperty
   property p_quiet;
      s_go ##0 first_source[31:0] == 32'h7FC00000 && second_source[31:0] == 32'h3F800000
         && !predicate_select[3] |=> !exc_taken;
   endproperty
   property p_wait;
      avs_read && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_done: assert property (p_done) else $error("no done after issue");
   a_idle: assert property (p_idle) else $error("codes moved without issue");
   a_cop: assert property (p_cop) else $error("cop unusable not taken");
   a_rsv: assert property (p_rsv) else $error("reserved format not taken");
   a_false: assert property (p_false) else $error("false predicate true");
   a_zero: assert property (p_zero) else $error("signed zeros unequal");
   a_qnan: assert property (p_qnan) else $error("nan not unordered");
   a_quiet: assert property (p_quiet) else $error("quiet nan trapped");
   a_wait: assert property (p_wait) else $error("read not answered");
endmodule : fp_compare_predicate_asserts

bind fp_compare_predicate fp_compare_predicate_asserts u_chk (.clock, .arst_n, .issue_valid,
   .operand_format, .predicate_select, .first_source, .second_source, .cop_usable,
   .unimpl_request, .done, .outcome, .exc_taken, .exc_cause, .cond_codes, .avs_read,
   .avs_waitrequest);

// [fp_issue_model.sv]
// issue side model: one compare at a time
module fp_issue_model
   import fp_compare_pkg::*;
(
   input  wire logic             clock,
   output logic                  issue_valid,
   output logic [1:0]            operand_format,
   output logic [3:0]            predicate_select,
   output logic [FLAG_IDX_W-1:0] flag_index,
   output logic [DBL_W-1:0]      first_source,
   output logic [DBL_W-1:0]      second_source,
   output logic                  cop_usable,
   output logic                  unimpl_request
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      issue_valid = 1'b0;
      operand_format = FMT_SINGLE;
      predicate_select = 4'h0;
      flag_index = 3'h0;
      first_source = 64'h0;
      second_source = 64'h0;
      cop_usable = 1'b1;
      unimpl_request = 1'b0;
   end
   task automatic issue(input logic [1:0] f, input logic [3:0] s, input logic [2:0] i,
                        input logic [63:0] a, input logic [63:0] b, input logic cu,
                        input logic ui);
      @(posedge clock);
      issue_valid <= 1'b1;
      operand_format <= f;
      predicate_select <= s;
      flag_index <= i;
      first_source <= a;
      second_source <= b;
      cop_usable <= cu;
      unimpl_request <= ui;
      @(posedge clock);
      issue_valid <= 1'b0;
      // operands released: show a changed value
      first_source <= ~a;
      second_source <= ~b;
      @(negedge clock);
   endtask : issue
endmodule : fp_issue_model

// [testbench.sv]
// self-checking bench for the compare unit
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fp_compare_pkg::*;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
   // ==========================================================
   // signals
   // ==========================================================
   logic clock = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
   logic avs_waitrequest, irq, issue_valid, cop_usable, unimpl_request;
   logic done, outcome, exc_taken, exc_unimplemented;
   logic [1:0] operand_format, exc_cause;
   logic [3:0] predicate_select;
   logic [2:0] flag_index;
   logic [63:0] first_source, second_source;
   logic [7:0] cond_codes, ccx = 8'h00;
   logic [31:0] va [4] = '{32'h3F800000, 32'h00000000, 32'h7FC00000, 32'h7F800001};
   logic [31:0] vb [4] = '{32'h40000000, 32'h80000000, 32'h3F800000, 32'h3F800000};
   logic [2:0] rel [4] = '{3'h4, 3'h2, 3'h1, 3'h1};
   logic [1:0] cz [3] = '{CAUSE_COP_UNUSABLE, CAUSE_RESERVED, CAUSE_NONE};
   logic ex;
   int errors = 0, n_compared = 0;
   initial begin
      forever #2.5 clock = ~clock;
   end
   fp_issue_model im (.clock, .issue_valid, .operand_format, .predicate_select, .flag_index,
      .first_source, .second_source, .cop_usable, .unimpl_request);
   fp_compare_predicate uut (.clock, .arst_n, .issue_valid, .operand_format, .predicate_select,
      .flag_index, .first_source, .second_source, .cop_usable, .unimpl_request, .done,
      .outcome, .exc_taken, .exc_cause, .exc_unimplemented, .cond_codes, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
   // ==========================================================
   // tasks
   // ==========================================================
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge clock);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (k = 0; k < 50; k++) begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 50) begin
         errors++;
         end_sim();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      `CHK(avs_waitrequest, 1'b1)
      `CHK(cond_codes, CC_RESET)
      bus(1'b0, REG_IRQ_MASK, 32'h0, r);
      `CHK(r[2:0], IRQ_MASK_RESET)
      bus(1'b0, 4'hC, 32'h0, r);
      `CHK(r, RDATA_ZERO)
      $display("test reset done");
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 16; s++) begin
            bus(1'b1, REG_CSR, 32'h1, r);
            ex = |(s[2:0] & rel[p]);
            ccx[s[2:0]] = ex;
            im.issue(FMT_SINGLE, s[3:0], s[2:0], {32'h0, va[p]}, {32'h0, vb[p]}, 1'b1, 1'b0);
            `CHK(done, 1'b1)
            `CHK(outcome, ex)
            `CHK(cond_codes, ccx)
            `CHK(exc_taken, 1'b0)
            bus(1'b0, REG_CSR, 32'h0, r);
            `CHK(r[CSR_INV_FLAG], (p == 3) || (p == 2 && s[3]))
            `CHK(r[15:8], ccx)
         end
      end
      $display("test predicates done");
      bus(1'b1, REG_CSR, 32'h3, r);
      im.issue(FMT_SINGLE, 4'h1, 3'h4, {32'h0, va[3]}, {32'h0, vb[3]}, 1'b1, 1'b0);
      `CHK(exc_taken, 1'b1)
      `CHK(exc_cause, CAUSE_INVALID)
      `CHK(cond_codes, ccx)
      bus(1'b1, REG_CSR, 32'h1, r);
      for (int k = 0; k < 3; k++) begin
         im.issue(k == 1 ? 2'h3 : FMT_SINGLE, 4'h4, 3'h0, 64'h3F800000, 64'h40000000,
                  k != 0, k == 2);
         `CHK(exc_cause, cz[k])
         `CHK(exc_unimplemented, k == 2)
         `CHK(cond_codes, ccx)
      end
      $display("test exceptions done");
      im.issue(FMT_PAIRED_SINGLE, 4'h4, 3'h2, {va[0], vb[0]}, {vb[0], va[0]}, 1'b1, 1'b0);
      ccx[3:2] = 2'b10;
      `CHK(cond_codes, ccx)
      im.issue(FMT_PAIRED_SINGLE, 4'h2, 3'h6, {va[3], vb[2]}, {vb[2], vb[2]}, 1'b1, 1'b0);
      ccx[7:6] = 2'b01;
      `CHK(cond_codes, ccx)
      bus(1'b0, REG_CSR, 32'h0, r);
      `CHK(r[CSR_INV_FLAG], 1'b1)
      im.issue(FMT_DOUBLE, 4'h4, 3'h0, 64'h3FF0000000000000, 64'h4000000000000000, 1'b1, 1'b0);
      ccx[0] = 1'b1;
      `CHK(outcome, 1'b1)
      `CHK(cond_codes, ccx)
      $display("test formats done");
      bus(1'b1, REG_IRQ_STATUS, 32'h7, r);
      bus(1'b1, REG_IRQ_MASK, 32'h1, r);
      im.issue(FMT_SINGLE, 4'h2, 3'h1, 64'h0, 64'h80000000, 1'b1, 1'b0);
      `CHK(outcome, 1'b1)
      bus(1'b0, REG_IRQ_STATUS, 32'h0, r);
      `CHK(r[2:0], 3'h1)
      @(negedge clock);
      `CHK(irq, 1'b1)
      bus(1'b1, REG_IRQ_STATUS, 32'h7, r);
      repeat (2) @(negedge clock);
      `CHK(irq, 1'b0)
      bus(1'b1, REG_IRQ_MASK, 32'h0, r);
      im.issue(FMT_SINGLE, 4'h1, 3'h1, 64'h0, 64'h0, 1'b1, 1'b0);
      repeat (2) @(negedge clock);
      `CHK(irq, 1'b0)
      $display("test interrupt done");
      end_sim();
   end
endmodule : testbench
